// file: hw/psil_pkg.sv
package psil_pkg;
  // Register offsets
  localparam logic [7:0] FAULT_ADDR = 8'h2e;
  localparam logic [7:0] LIVE_STATUS_ADDR = 8'h2f;
  localparam logic [7:0] PIN1_SOURCE_MASK_ADDR = 8'h30;
  localparam logic [7:0] PIN2_SOURCE_MASK_ADDR = 8'h31;
  localparam logic [7:0] IRQ_ENABLE_LOW_ADDR = 8'h32;
  localparam logic [7:0] IRQ_ENABLE_HIGH_ADDR = 8'h33;
  localparam logic [7:0] IRQ_FLAGS_LOW_ADDR = 8'h34;
  localparam logic [7:0] IRQ_FLAGS_HIGH_ADDR = 8'h35;
  localparam logic [7:0] SHIP_REQUEST_ADDR = 8'h36;

  // Field positions
  localparam int THERMAL_FAULT_BIT = 0;
  localparam int BUTTON_HELD_BIT = 5;
  localparam int CHARGE_DONE_BIT = 4;
  localparam int BUS_POWER_BIT = 3;
  localparam int BATTERY_BIT = 2;
  localparam int BUCKBOOST_GOOD_BIT = 1;
  localparam int BUCK_GOOD_BIT = 0;
  localparam int POLARITY_BIT = 7;
  localparam int ACCUM_FLAG_BIT = 6;
  localparam int BUTTON_FLAG_BIT = 7;
  localparam int WATCHDOG_FLAG_BIT = 6;
  localparam int BUCK_FLAG_BIT = 5;
  localparam int BUCKBOOST_FLAG_BIT = 4;
  localparam int SHIP_BIT = 0;

  // Implemented-bit masks; the rest read as zero
  localparam logic [7:0] FAULT_USED = 8'hf5;
  localparam logic [7:0] SOURCE_MASK_USED = 8'h9f;
  localparam logic [7:0] HIGH_IRQ_USED = 8'hf0;
  localparam logic [7:0] SHIP_USED = 8'h01;

  // Reset values; factory-set fields come up as this neutral value
  localparam logic [7:0] PIN1_SOURCE_MASK_RESET = 8'h00;
  localparam logic [7:0] PIN2_SOURCE_MASK_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_LOW_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_HIGH_RESET = 8'h00;
  localparam logic [7:0] SHIP_REQUEST_RESET = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BUTTON_DEGLITCH_NS = 50000;
  localparam int BUTTON_DEGLITCH_CYCLES = (BUTTON_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DG_CNT_W = 10;
  localparam int ACCUM_W = 12;
endpackage

// file: hw/psil_top.sv
`timescale 1ns/1ps
// Function
// - Fault bits clear by write-one or power cycle
// - Thermal shutdown sets fault bit zero
// - Status bit five: button held past deglitch
// - Status bit four: charge complete state
// - Status bit three: bus power in window
// - Status bit two: battery ok, gauge enabled
// - Status bit one: buck-boost good, fixed mode
// - Status bit zero: buck good
// - Pin A polarity from mask bit seven
// - Pin A ORs masked status sources
// - Pin B polarity bit, default zero
// - Pin B separate mask, default zero
// - Buck mask ignored in load-switch mode
// - Low enable register, eight causes
// - High enable register, four causes
// - Low flags set; accumulator overflow at 4096
// - Reading a flag register clears it
// - High flags: button, watchdog, buck, buck-boost
// - Buck good change raises buck flag
// - Ship bit zero requests shipment mode
module psil_top (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic bus_power_present_in,
  input wire logic bus_power_in_window_in,
  input wire logic charge_done_in,
  input wire logic battery_above_weak_in,
  input wire logic fuel_gauge_en_in,
  input wire logic buckboost_power_good_in,
  input wire logic buckboost_fixed_mode_in,
  input wire logic buck_power_good_in,
  input wire logic buck_load_switch_in,
  input wire logic manual_reset_button_n_in,
  input wire logic thermal_shutdown_fault_in,
  input wire logic [7:0] fault_events_in,
  input wire logic [7:0] low_irq_events_in,
  input wire logic accum_step_in,
  input wire logic watchdog_alarm_in,
  output logic good_pin_a_out,
  output logic good_pin_b_out,
  output logic irq_out,
  output logic ship_state_request_out
);

  logic [7:0] fault_r;
  logic [7:0] pin1_mask_r;
  logic [7:0] pin2_mask_r;
  logic [7:0] en_low_r;
  logic [7:0] en_high_r;
  logic [7:0] flags_low_r;
  logic [7:0] flags_high_r;
  logic [7:0] ship_r;
  logic [psil_pkg::DG_CNT_W-1:0] dg_cnt_r;
  logic button_held_r;
  logic button_held_d_r;
  logic [psil_pkg::ACCUM_W-1:0] accum_r;
  logic bus_present_d_r;
  logic buck_good_d_r;
  logic buckboost_good_d_r;
  logic [7:0] status;
  logic [7:0] read_mux;
  logic [7:0] fault_set;
  logic [7:0] low_set;
  logic [7:0] high_set;
  logic bus_power_lost;
  logic accum_wrap;
  logic [4:0] pin_sources;

  //////////////////////////////////////////////////////////////////////
  // Live status
  always_comb begin
    status = 8'h00;
    status[psil_pkg::BUTTON_HELD_BIT] = button_held_r;
    status[psil_pkg::CHARGE_DONE_BIT] = charge_done_in;
    status[psil_pkg::BUS_POWER_BIT] = bus_power_in_window_in;
    status[psil_pkg::BATTERY_BIT] = battery_above_weak_in & fuel_gauge_en_in;
    status[psil_pkg::BUCKBOOST_GOOD_BIT] = buckboost_power_good_in & buckboost_fixed_mode_in;
    status[psil_pkg::BUCK_GOOD_BIT] = buck_power_good_in;
  end

  // Button must stay low for the full deglitch time before it counts
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dg_cnt_r <= '0;
      button_held_r <= 1'b0;
    end else if (ce_in) begin
      if (manual_reset_button_n_in) begin
        dg_cnt_r <= '0;
        button_held_r <= 1'b0;
      end else if (dg_cnt_r == psil_pkg::DG_CNT_W'(psil_pkg::BUTTON_DEGLITCH_CYCLES)) begin
        button_held_r <= 1'b1;
      end else begin
        dg_cnt_r <= dg_cnt_r + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Event detection
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      button_held_d_r <= 1'b0;
      bus_present_d_r <= 1'b0;
      buck_good_d_r <= 1'b0;
      buckboost_good_d_r <= 1'b0;
      accum_r <= '0;
    end else if (ce_in) begin
      button_held_d_r <= button_held_r;
      bus_present_d_r <= bus_power_present_in;
      buck_good_d_r <= status[psil_pkg::BUCK_GOOD_BIT];
      buckboost_good_d_r <= status[psil_pkg::BUCKBOOST_GOOD_BIT];
      if (accum_step_in) begin
        accum_r <= accum_r + 1'b1;
      end
    end
  end

  assign accum_wrap = accum_step_in & (&accum_r);
  assign bus_power_lost = bus_present_d_r & ~bus_power_present_in;

  always_comb begin
    fault_set = fault_events_in & psil_pkg::FAULT_USED;
    fault_set[psil_pkg::THERMAL_FAULT_BIT] = thermal_shutdown_fault_in;
    low_set = low_irq_events_in;
    low_set[psil_pkg::ACCUM_FLAG_BIT] = accum_wrap;
    high_set = 8'h00;
    high_set[psil_pkg::BUTTON_FLAG_BIT] = button_held_r & ~button_held_d_r;
    high_set[psil_pkg::WATCHDOG_FLAG_BIT] = watchdog_alarm_in;
    high_set[psil_pkg::BUCK_FLAG_BIT] = status[psil_pkg::BUCK_GOOD_BIT] ^ buck_good_d_r;
    high_set[psil_pkg::BUCKBOOST_FLAG_BIT] = status[psil_pkg::BUCKBOOST_GOOD_BIT] ^ buckboost_good_d_r;
  end

  //////////////////////////////////////////////////////////////////////
  // Fault register: new faults win over a clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_r <= 8'h00;
    end else if (ce_in) begin
      if (bus_power_lost) begin
        fault_r <= fault_set;
      end else if (reg_wr_in && reg_addr_in == psil_pkg::FAULT_ADDR) begin
        fault_r <= (fault_r & ~reg_wdata_in) | fault_set;
      end else begin
        fault_r <= fault_r | fault_set;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Writable configuration
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin1_mask_r <= psil_pkg::PIN1_SOURCE_MASK_RESET;
      pin2_mask_r <= psil_pkg::PIN2_SOURCE_MASK_RESET;
      en_low_r <= psil_pkg::IRQ_ENABLE_LOW_RESET;
      en_high_r <= psil_pkg::IRQ_ENABLE_HIGH_RESET;
      ship_r <= psil_pkg::SHIP_REQUEST_RESET;
    end else if (ce_in && reg_wr_in) begin
      case (reg_addr_in)
        psil_pkg::PIN1_SOURCE_MASK_ADDR: pin1_mask_r <= reg_wdata_in & psil_pkg::SOURCE_MASK_USED;
        psil_pkg::PIN2_SOURCE_MASK_ADDR: pin2_mask_r <= reg_wdata_in & psil_pkg::SOURCE_MASK_USED;
        psil_pkg::IRQ_ENABLE_LOW_ADDR: en_low_r <= reg_wdata_in;
        psil_pkg::IRQ_ENABLE_HIGH_ADDR: en_high_r <= reg_wdata_in & psil_pkg::HIGH_IRQ_USED;
        psil_pkg::SHIP_REQUEST_ADDR: ship_r <= reg_wdata_in & psil_pkg::SHIP_USED;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Flags: read clears, but an event in the read cycle survives
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_low_r <= 8'h00;
      flags_high_r <= 8'h00;
    end else if (ce_in) begin
      if (reg_rd_in && reg_addr_in == psil_pkg::IRQ_FLAGS_LOW_ADDR) begin
        flags_low_r <= low_set;
      end else begin
        flags_low_r <= flags_low_r | low_set;
      end
      if (reg_rd_in && reg_addr_in == psil_pkg::IRQ_FLAGS_HIGH_ADDR) begin
        flags_high_r <= high_set;
      end else begin
        flags_high_r <= flags_high_r | high_set;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    case (reg_addr_in)
      psil_pkg::FAULT_ADDR: read_mux = fault_r;
      psil_pkg::LIVE_STATUS_ADDR: read_mux = status;
      psil_pkg::PIN1_SOURCE_MASK_ADDR: read_mux = pin1_mask_r;
      psil_pkg::PIN2_SOURCE_MASK_ADDR: read_mux = pin2_mask_r;
      psil_pkg::IRQ_ENABLE_LOW_ADDR: read_mux = en_low_r;
      psil_pkg::IRQ_ENABLE_HIGH_ADDR: read_mux = en_high_r;
      psil_pkg::IRQ_FLAGS_LOW_ADDR: read_mux = flags_low_r;
      psil_pkg::IRQ_FLAGS_HIGH_ADDR: read_mux = flags_high_r;
      psil_pkg::SHIP_REQUEST_ADDR: read_mux = ship_r;
      default: read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      reg_rdata_out <= read_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Output pins
  always_comb begin
    pin_sources = status[4:0];
    if (buck_load_switch_in) begin
      pin_sources[psil_pkg::BUCK_GOOD_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      good_pin_a_out <= 1'b0;
      good_pin_b_out <= 1'b0;
      irq_out <= 1'b0;
      ship_state_request_out <= 1'b0;
    end else if (ce_in) begin
      good_pin_a_out <= (|(pin_sources & pin1_mask_r[4:0])) ^ pin1_mask_r[psil_pkg::POLARITY_BIT];
      good_pin_b_out <= (|(pin_sources & pin2_mask_r[4:0])) ^ pin2_mask_r[psil_pkg::POLARITY_BIT];
      irq_out <= |{flags_low_r & en_low_r, flags_high_r & en_high_r};
      ship_state_request_out <= ship_r[psil_pkg::SHIP_BIT];
    end
  end

endmodule

// file: bench/psil_checker_asserts.sv
`timescale 1ns/1ps
module psil_checker (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic charge_done_in,
  input wire logic bus_power_in_window_in,
  input wire logic battery_above_weak_in,
  input wire logic fuel_gauge_en_in,
  input wire logic buckboost_power_good_in,
  input wire logic buckboost_fixed_mode_in,
  input wire logic buck_power_good_in,
  input wire logic buck_load_switch_in,
  input wire logic good_pin_a_out,
  input wire logic good_pin_b_out,
  input wire logic irq_out,
  input wire logic ship_state_request_out
);
  logic [7:0] mask_a_r, mask_b_r, en_lo_r, en_hi_r;
  logic [4:0] src, src_pin;
  logic exp_a, exp_b;
  assign src = {charge_done_in, bus_power_in_window_in, battery_above_weak_in & fuel_gauge_en_in,
    buckboost_power_good_in & buckboost_fixed_mode_in, buck_power_good_in};
  // Buck source drops out of pin routing only
  assign src_pin = src & {4'hf, ~buck_load_switch_in};
  assign exp_a = (|(src_pin & mask_a_r[4:0])) ^ mask_a_r[7];
  assign exp_b = (|(src_pin & mask_b_r[4:0])) ^ mask_b_r[7];
  // Mirror of writes seen at the port
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_a_r <= 8'h00;
      mask_b_r <= 8'h00;
      en_lo_r <= 8'h00;
      en_hi_r <= 8'h00;
    end else if (reg_wr_in && ce_in) begin
      if (reg_addr_in == 8'h30) mask_a_r <= reg_wdata_in;
      if (reg_addr_in == 8'h31) mask_b_r <= reg_wdata_in;
      if (reg_addr_in == 8'h32) en_lo_r <= reg_wdata_in;
      // Low nibble of the high enables is not stored
      if (reg_addr_in == 8'h33) en_hi_r <= reg_wdata_in & 8'hf0;
    end
  end
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_rd(logic [7:0] a);
    reg_rd_in && ce_in && reg_addr_in == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    reg_wr_in && ce_in && reg_addr_in == a;
  endsequence
  pin_a_route_a: assert property (good_pin_a_out == $past(exp_a))
    else $error("pin a level wrong");
  pin_b_route_a: assert property (good_pin_b_out == $past(exp_b))
    else $error("pin b level wrong");
  irq_quiet_a: assert property ($past(en_lo_r | en_hi_r) == 8'h00 |-> !irq_out)
    else $error("irq high with no enable");
  ship_set_a: assert property (s_wr(8'h36) ##0 reg_wdata_in[0] |-> ##[1:2] ship_state_request_out)
    else $error("ship request not set");
  ship_clr_a: assert property (s_wr(8'h36) ##0 !reg_wdata_in[0] |-> ##[1:2] !ship_state_request_out)
    else $error("ship request not cleared");
  mask_read_a: assert property (s_rd(8'h30) |=> reg_rdata_out == ($past(mask_a_r) & 8'h9f))
    else $error("mask readback wrong");
  status_read_a: assert property (s_rd(8'h2f) |=> reg_rdata_out[4:0] == $past(src))
    else $error("status readback wrong");
  unmapped_read_a: assert property (reg_rd_in && ce_in && reg_addr_in > 8'h36 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(reg_rd_in && ce_in) |=> $stable(reg_rdata_out))
    else $error("read data moved without read");
endmodule
bind psil_top psil_checker i_chk (
  .clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in),
  .ce_in(ce_in),
  .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .charge_done_in(charge_done_in),
  .bus_power_in_window_in(bus_power_in_window_in),
  .battery_above_weak_in(battery_above_weak_in),
  .fuel_gauge_en_in(fuel_gauge_en_in),
  .buckboost_power_good_in(buckboost_power_good_in),
  .buckboost_fixed_mode_in(buckboost_fixed_mode_in),
  .buck_power_good_in(buck_power_good_in),
  .buck_load_switch_in(buck_load_switch_in),
  .good_pin_a_out(good_pin_a_out),
  .good_pin_b_out(good_pin_b_out),
  .irq_out(irq_out),
  .ship_state_request_out(ship_state_request_out)
);

// file: bench/psil_host_model.sv
`timescale 1ns/1ps
module psil_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out = 8'h00,
  output logic wr_out = 1'h0,
  output logic rd_out = 1'h0,
  output logic [7:0] wdata_out = 8'h00
);
  // One access per call; idle lines show the inverse so stale values never pass
  // Strobes drop at the edge that takes them; read data is picked up one edge later
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= w;
    rd_out <= !w;
    @(posedge clk_in);
    wr_out <= 1'h0;
    rd_out <= 1'h0;
    addr_out <= ~a;
    wdata_out <= ~d;
    @(posedge clk_in);
    q = rdata_in;
  endtask
endmodule

// file: bench/pmic_status_interrupt_logic_tb.sv
`timescale 1ns/1ps
module pmic_status_interrupt_logic_tb;
  logic clk_sys_in = 1'h0, rst_n_in = 1'h0, bus_pres = 1'h1, btn_n = 1'h1;
  logic win = 1'h0, chg = 1'h0, bat = 1'h0, gauge = 1'h0, bbg = 1'h0, bbfix = 1'h0, bkg = 1'h0, ls = 1'h0;
  logic tsd = 1'h0, acc = 1'h0, wdog = 1'h0, ce = 1'h1, wr, rd, pin_a, pin_b, irq, ship;
  logic [7:0] faults = 8'h00, low_ev = 8'h00, addr, wdata, rdata, q;
  logic [7:0] ra [5] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h36};
  logic [7:0] re [5] = '{8'h9f, 8'h9f, 8'hff, 8'hf0, 8'h01};
  int err_total = 0, n_checks = 0;
  psil_top i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .bus_power_present_in(bus_pres),
    .bus_power_in_window_in(win), .charge_done_in(chg), .battery_above_weak_in(bat), .fuel_gauge_en_in(gauge),
    .buckboost_power_good_in(bbg), .buckboost_fixed_mode_in(bbfix), .buck_power_good_in(bkg),
    .buck_load_switch_in(ls), .manual_reset_button_n_in(btn_n), .thermal_shutdown_fault_in(tsd),
    .fault_events_in(faults), .low_irq_events_in(low_ev), .accum_step_in(acc), .watchdog_alarm_in(wdog),
    .good_pin_a_out(pin_a), .good_pin_b_out(pin_b), .irq_out(irq), .ship_state_request_out(ship));
  psil_host_model i_host (.clk_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata));
  //////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    i_host.access(1'h1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_host.access(1'h0, a, 8'h00, q);
    chk("register read", exp, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #2500000;
    err_total++;
    end_of_test();
  end
  initial begin
    cyc(6);
    rst_n_in <= 1'h1;
    for (int i = 0; i < 5; i++) rd_chk(ra[i], 8'h00);
    rd_chk(8'h40, 8'h00);
    for (int i = 0; i < 5; i++) wr_reg(ra[i], 8'hff);
    for (int i = 0; i < 5; i++) rd_chk(ra[i], re[i]);
    chk("ship pin", 8'h01, {7'h00, ship});
    wr_reg(8'h36, 8'h00);
    wr_reg(8'h30, 8'h88);
    wr_reg(8'h31, 8'h01);
    {chg, win, bat, bbg, bbfix, bkg, ls} <= 7'h7f;
    cyc(3);
    rd_chk(8'h2f, 8'h1b);
    chk("pin a", 8'h00, {7'h00, pin_a});
    chk("pin b", 8'h00, {7'h00, pin_b});
    {ls, gauge, win} <= 3'h2;
    cyc(3);
    chk("pin a", 8'h01, {7'h00, pin_a});
    chk("pin b", 8'h01, {7'h00, pin_b});
    rd_chk(8'h2f, 8'h17);
    chk("irq", 8'h01, {7'h00, irq});
    rd_chk(8'h35, 8'h30);
    rd_chk(8'h35, 8'h00);
    cyc(2);
    chk("irq", 8'h00, {7'h00, irq});
    btn_n <= 1'h0;
    // Held bit must appear one cycle after the deglitch count ends, not before
    cyc(497);
    rd_chk(8'h2f, 8'h17);
    rd_chk(8'h2f, 8'h37);
    btn_n <= 1'h1;
    wdog <= 1'h1;
    cyc(1);
    wdog <= 1'h0;
    rd_chk(8'h35, 8'hc0);
    low_ev <= 8'hff;
    cyc(1);
    low_ev <= 8'h00;
    rd_chk(8'h34, 8'hbf);
    // Accumulator boundary: one step short, then the wrapping step
    for (int i = 0; i < 4096; i++) begin
      if (i == 4095) rd_chk(8'h34, 8'h00);
      acc <= 1'h1;
      cyc(1);
      acc <= 1'h0;
      cyc(1);
    end
    rd_chk(8'h34, 8'h40);
    {tsd, faults} <= 9'h1ff;
    cyc(1);
    {tsd, faults} <= 9'h000;
    rd_chk(8'h2e, 8'hf5);
    wr_reg(8'h2e, 8'hff);
    rd_chk(8'h2e, 8'h00);
    tsd <= 1'h1;
    cyc(1);
    {tsd, bus_pres} <= 2'h0;
    cyc(2);
    bus_pres <= 1'h1;
    rd_chk(8'h2e, 8'h00);
    // Charge done, fixed mode and buck good all low
    {chg, bbfix, bkg} <= 3'h0;
    cyc(3);
    rd_chk(8'h2f, 8'h04);
    chk("pin b", 8'h00, {7'h00, pin_b});
    rd_chk(8'h35, 8'h30);
    // With the clock enable low a write must leave no trace
    ce <= 1'h0;
    wr_reg(8'h36, 8'h01);
    ce <= 1'h1;
    rd_chk(8'h36, 8'h00);
    chk("ship pin", 8'h00, {7'h00, ship});
    wr_reg(8'h32, 8'h00);
    wr_reg(8'h33, 8'h00);
    cyc(3);
    end_of_test();
  end
endmodule
